/* common/vcfc_consts.svh */
`ifndef VCFC_CONSTS_SVH
`define VCFC_CONSTS_SVH

`define VCFC_FN_NOP          8'h00
`define VCFC_FN_TRAIN_ISO    8'h03
`define VCFC_FN_ENCODE       8'h05
`define VCFC_FN_DECODE       8'h06
`define VCFC_FN_TONE         8'h07
`define VCFC_FN_RECOG_ISO    8'h0B
`define VCFC_FN_LOAD_ISO     8'h0E
`define VCFC_FN_TRAIN_CX     8'h10
`define VCFC_FN_RECOG_CX     8'h11
`define VCFC_FN_EXTRACT_CX   8'h12
`define VCFC_FN_LOAD_CX      8'h13

`define VCFC_FLAG_END_PAUSE  0
`define VCFC_FLAG_RATE_6K    1
`define VCFC_FLAG_VOICE_DET  2
`define VCFC_FLAG_REWIND     3
`define VCFC_FLAG_RESERVED   4
`define VCFC_FLAG_RESIDENT   5
`define VCFC_FLAG_STATE_INT  6
`define VCFC_FLAG_DTMF_INT   7

`define VCFC_ST_OK           8'h00
`define VCFC_ST_PARAM        8'h03
`define VCFC_ST_BUSY         8'h06
`define VCFC_ST_INVALID      8'h09
`define VCFC_ST_RING         8'h0B
`define VCFC_ST_VOICE        8'h10
`define VCFC_ST_DTMF         8'h11
`define VCFC_ST_OFF_HOOK     8'h12
`define VCFC_ST_ON_HOOK      8'h15

`define VCFC_LEN_PLAIN       8'h04
`define VCFC_LEN_TRAIN       8'h06
`define VCFC_LEN_DTMF        8'h08
`define VCFC_LEN_NOP         8'h0A

`define VCFC_KIND_TLEN       2'h0
`define VCFC_KIND_TMPL       2'h1
`define VCFC_KIND_EVENT      2'h2

`define VCFC_FW_VOICE_DET    300
`define VCFC_FW_STATE_INT    301
`define VCFC_FW_DTMF_INT     400
`define VCFC_FW_VER_DEF      8'h04
`define VCFC_FW_REV_DEF      8'h00

`define VCFC_CLK_KHZ         125000
`define VCFC_SPEECH_MAX_MS   7500
`define VCFC_PAUSE_MS        240
`define VCFC_SPEECH_MAX_CYC  (`VCFC_SPEECH_MAX_MS * `VCFC_CLK_KHZ)
`define VCFC_PAUSE_CYC       (`VCFC_PAUSE_MS * `VCFC_CLK_KHZ)
`define VCFC_CNT_W           30

`endif

/* common/vcfc_pkg.sv */
package vcfc_pkg;

	typedef enum logic [6:0] {
		VCFC_IDLE   = 7'b000_0001,
		VCFC_TLEN   = 7'b000_0010,
		VCFC_TMPL   = 7'b000_0100,
		VCFC_RUN    = 7'b000_1000,
		VCFC_EVENT  = 7'b001_0000,
		VCFC_SEND   = 7'b010_0000,
		VCFC_STATUS = 7'b100_0000
	} vcfc_state_t;

	typedef struct packed {
		logic        heard;
		logic [29:0] speech_cnt;
		logic [29:0] silence_cnt;
		logic        stop;
	} vcfc_timer_t;

	typedef struct packed {
		vcfc_state_t st;
		logic [7:0]  func;
		logic [7:0]  flags;
		logic        tel;
		logic [7:0]  wend;
		logic [7:0]  code;
		logic [7:0]  len;
		logic [15:0] extra;
		logic        continuous_recognition_prev;
		logic [1:0]  ring_s;
		logic [1:0]  hook_s;
		logic        ring_q;
		logic        hook_q;
		logic        req_rec;
		logic [1:0]  req_kind;
		logic        send_tmpl;
		logic        audio_run;
		logic        rate_6k;
		logic        rewind;
		logic [7:0]  rewind_idx;
		logic        event_valid;
		logic [7:0]  event_idx;
		logic        stat_valid;
		logic [7:0]  stat_len;
		logic [15:0] stat_word;
		logic [15:0] stat_extra;
		logic        busy_err;
		logic        buf_hold;
	} vcfc_core_t;

endpackage : vcfc_pkg

/* dv/testbench.sv */
`timescale 1ns/1ns
`include "vcfc_consts.svh"

module testbench;
	import vcfc_pkg::*;
	// Short counts keep the run brief
	localparam int unsigned SPEECH_MAX = 40;
	localparam int unsigned PAUSE      = 10;
	logic        i_clock = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0, i_tel_cmd = 1'b0;
	logic        i_op_done = 1'b0, i_speech = 1'b0, i_play_silence = 1'b0, i_word_event = 1'b0;
	logic        i_dtmf_valid = 1'b0, i_ring = 1'b0, i_hook_off = 1'b0, rec_done;
	logic [7:0]  i_func = 8'h00, i_flags = 8'h00, i_word_end = 8'h00, i_peak = 8'h00;
	logic [7:0]  i_noise = 8'h00, i_word_event_idx = 8'h00, i_dtmf_code = 8'h00, rw_idx;
	logic [3:0]  host_delay = 4'h0;
	logic        o_req_rec, o_send_tmpl, o_audio_run, o_rate_6k, o_rewind, o_event_valid;
	logic        o_stat_valid, o_busy_err, o_buf_hold;
	logic [1:0]  o_req_kind;
	logic [7:0]  o_rewind_idx, o_event_idx, o_stat_len;
	logic [15:0] o_stat_word, o_stat_extra;
	logic [1:0]  kinds[$];
	int          num_errors = 0, num_checks = 0, n = 0;
	int          ev_cnt = 0, rw_cnt = 0, busy_cnt = 0, run_cnt = 0;

	vcfc_core #(.SPEECH_MAX_CYC(SPEECH_MAX), .PAUSE_CYC(PAUSE)) u_vcfc_core (
		.i_clock, .i_rst_n, .i_cmd_valid, .i_tel_cmd, .i_func, .i_flags, .i_word_end,
		.i_rec_done(rec_done), .i_op_done, .i_op_error(1'b0), .i_op_code(8'h00),
		.i_peak, .i_noise, .i_speech, .i_play_silence, .i_word_event, .i_word_event_idx,
		.i_dtmf_valid, .i_dtmf_code, .i_ring, .i_hook_off, .o_req_rec, .o_req_kind,
		.o_send_tmpl, .o_audio_run, .o_rate_6k, .o_rewind, .o_rewind_idx, .o_event_valid,
		.o_event_idx, .o_stat_valid, .o_stat_len, .o_stat_word, .o_stat_extra,
		.o_busy_err, .o_buf_hold
	);

	vcfc_host_model u_vcfc_host_model (
		.i_clock, .i_rst_n, .i_req_rec(o_req_rec), .i_send_tmpl(o_send_tmpl),
		.i_delay(host_delay), .o_rec_done(rec_done)
	);

	always #4 i_clock = ~i_clock;

	// Values seen at the edge are those the core itself samples
	always @(posedge i_clock) begin
		ev_cnt   += int'(o_event_valid === 1'b1);
		rw_cnt   += int'(o_rewind === 1'b1);
		busy_cnt += int'(o_busy_err === 1'b1);
		run_cnt  += int'(o_audio_run === 1'b1);
		if (o_rewind === 1'b1) rw_idx = o_rewind_idx;
		if (rec_done === 1'b1) kinds.push_back(o_send_tmpl ? 2'h3 : o_req_kind);
	end

	task automatic check_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check_val

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic cmd(input logic [7:0] f, input logic [7:0] fl, input logic [7:0] we,
			input logic tel);
		#1;
		ev_cnt = 0;
		rw_cnt = 0;
		busy_cnt = 0;
		run_cnt = 0;
		kinds.delete();
		@(posedge i_clock);
		i_cmd_valid <= 1'b1;
		i_func      <= f;
		i_flags     <= fl & 8'hEF;
		i_word_end  <= we;
		i_tel_cmd   <= tel;
		@(posedge i_clock);
		i_cmd_valid <= 1'b0;
	endtask : cmd

	task automatic wait_stat(input logic [7:0] len, input logic [15:0] word);
		n = 0;
		do begin
			@(posedge i_clock);
			#1;
			n++;
		end while (o_stat_valid !== 1'b1 && n < 300);
		check_val("stat_valid", 16'h0001, {15'h0000, o_stat_valid});
		check_val("stat_len", {8'h00, len}, {8'h00, o_stat_len});
		check_val("stat_word", word, o_stat_word);
	endtask : wait_stat

	task automatic wait_run();
		n = 0;
		while (o_audio_run !== 1'b1 && n < 50) begin
			@(posedge i_clock);
			#1;
			n++;
		end
	endtask : wait_run

	task automatic op_done();
		@(posedge i_clock);
		i_op_done <= 1'b1;
		@(posedge i_clock);
		i_op_done <= 1'b0;
	endtask : op_done

	task automatic word_ev(input logic [7:0] idx);
		@(posedge i_clock);
		i_word_event     <= 1'b1;
		i_word_event_idx <= idx;
		@(posedge i_clock);
		i_word_event <= 1'b0;
	endtask : word_ev

	task automatic t_nop();
		cmd(8'h00, 8'h00, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_NOP, 16'h0000);
		check_val("nop_latency", 16'h0001, n[15:0]);
		check_val("nop_extra", {`VCFC_FW_VER_DEF, `VCFC_FW_REV_DEF}, o_stat_extra);
		cmd(8'h20, 8'h00, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_PLAIN, 16'h0003);
		$display("test nop done");
	endtask : t_nop

	task automatic t_busy_rate();
		cmd(8'h05, 8'h02, 8'h00, 1'b0);
		wait_run();
		check_val("encode_rate_6k", 16'h0000, {15'h0000, o_rate_6k});
		cmd(8'h00, 8'h00, 8'h00, 1'b0);
		repeat (3) @(posedge i_clock);
		check_val("busy_pulses", 16'h0001, busy_cnt[15:0]);
		op_done();
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		cmd(8'h00, 8'h02, 8'h00, 1'b1);
		wait_stat(`VCFC_LEN_PLAIN, 16'h0003);
		$display("test busy_rate done");
	endtask : t_busy_rate

	task automatic t_load();
		host_delay = 4'h3;
		cmd(8'h13, 8'h00, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		check_val("load_kinds", 16'h0211, {6'h00, kinds.size() == 2, 1'b0, kinds[0], kinds[1],
			4'h1});
		check_val("load_run", 16'h0000, run_cnt[15:0]);
		$display("test load done");
	endtask : t_load

	task automatic t_extract();
		host_delay = 4'h0;
		cmd(8'h11, 8'h20, 8'h00, 1'b0);
		wait_run();
		word_ev(8'h03);
		word_ev(8'h09);
		op_done();
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		check_val("event_count", 16'h0002, ev_cnt[15:0]);
		check_val("event_idx", 16'h0009, {8'h00, o_event_idx});
		check_val("resident_reqs", 16'h0000, 16'(kinds.size()));
		check_val("buf_hold", 16'h0001, {15'h0000, o_buf_hold});
		host_delay = 4'h2;
		repeat (2) begin
			cmd(8'h12, 8'h00, 8'h00, 1'b0);
			wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
			check_val("extract_seq", 16'h0223, {6'h00, kinds.size() == 2, 1'b0, 2'h0,
				kinds[0], 2'h0, kinds[1]});
		end
		cmd(8'h00, 8'h00, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_NOP, 16'h0000);
		check_val("buf_released", 16'h0000, {15'h0000, o_buf_hold});
		cmd(8'h12, 8'h00, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_PLAIN, 16'h0009);
		$display("test extract done");
	endtask : t_extract

	task automatic t_rewind_pause();
		cmd(8'h11, 8'h2A, 8'h5A, 1'b0);
		wait_run();
		repeat (2) @(posedge i_clock);
		check_val("rewind_idx", 16'h015A, {7'h00, rw_cnt == 1, rw_idx});
		check_val("rate_6k", 16'h0001, {15'h0000, o_rate_6k});
		op_done();
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		cmd(8'h11, 8'h21, 8'h00, 1'b0);
		@(posedge i_clock);
		i_speech <= 1'b1;
		repeat (5) @(posedge i_clock);
		i_speech <= 1'b0;
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		check_val("pause_gap", 16'h0001, {15'h0000, n >= PAUSE && n <= PAUSE + 6});
		cmd(8'h11, 8'h21, 8'h00, 1'b0);
		@(posedge i_clock);
		i_speech <= 1'b1;
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		check_val("speech_cap", 16'h0001, {15'h0000, n >= SPEECH_MAX && n <= SPEECH_MAX + 6});
		cmd(8'h11, 8'h20, 8'h00, 1'b0);
		repeat (60) @(posedge i_clock);
		check_val("no_pause_run", 16'h0001, {15'h0000, o_audio_run});
		i_speech <= 1'b0;
		op_done();
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		$display("test rewind_pause done");
	endtask : t_rewind_pause

	task automatic t_events();
		cmd(8'h07, 8'h40, 8'h00, 1'b0);
		@(posedge i_clock);
		i_ring <= 1'b1;
		repeat (6) @(posedge i_clock);
		op_done();
		wait_stat(`VCFC_LEN_PLAIN, 16'h0000);
		cmd(8'h06, 8'h40, 8'h00, 1'b0);
		wait_stat(`VCFC_LEN_PLAIN, 16'h000B);
		cmd(8'h00, 8'h40, 8'h00, 1'b1);
		wait_stat(`VCFC_LEN_PLAIN, 16'h000B);
		i_ring <= 1'b0;
		// Ring passes three flops before the abort logic sees it drop
		repeat (3) @(posedge i_clock);
		cmd(8'h06, 8'h40, 8'h00, 1'b0);
		repeat (3) @(posedge i_clock);
		i_hook_off <= 1'b1;
		wait_stat(`VCFC_LEN_PLAIN, 16'h0012);
		cmd(8'h06, 8'h40, 8'h00, 1'b0);
		repeat (3) @(posedge i_clock);
		i_hook_off <= 1'b0;
		wait_stat(`VCFC_LEN_PLAIN, 16'h0015);
		host_delay = 4'h1;
		cmd(8'h11, 8'h80, 8'h00, 1'b0);
		wait_run();
		check_val("tmpl_reqs", 16'h0001, {15'h0000, kinds.size() == 2 && kinds[1] == 2'h1});
		@(posedge i_clock);
		i_dtmf_valid <= 1'b1;
		i_dtmf_code  <= 8'h35;
		@(posedge i_clock);
		i_dtmf_valid <= 1'b0;
		wait_stat(`VCFC_LEN_DTMF, 16'h0011);
		check_val("dtmf_extra", 16'h0035, o_stat_extra);
		cmd(8'h06, 8'h04, 8'h00, 1'b0);
		wait_run();
		@(posedge i_clock);
		i_speech       <= 1'b1;
		i_play_silence <= 1'b1;
		wait_stat(`VCFC_LEN_PLAIN, 16'h0010);
		i_speech       <= 1'b0;
		i_play_silence <= 1'b0;
		$display("test events done");
	endtask : t_events

	task automatic t_train();
		cmd(8'h10, 8'h00, 8'h00, 1'b0);
		wait_run();
		i_peak  <= 8'h7A;
		i_noise <= 8'h13;
		op_done();
		wait_stat(`VCFC_LEN_TRAIN, 16'h0000);
		check_val("train_extra", 16'h137A, o_stat_extra);
		check_val("train_take", 16'h0003, {14'h0000, kinds[0]});
		$display("test train done");
	endtask : t_train

	initial begin
		#(8 * 6000);
		num_errors++;
		$display("[FAIL] watchdog expected finish seen timeout");
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_nop();
		t_busy_rate();
		t_load();
		t_extract();
		t_rewind_pause();
		t_events();
		t_train();
		print_verdict();
	end
endmodule : testbench

/* dv/vcfc_host_model.sv */
`timescale 1ns/1ns

module vcfc_host_model (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic       i_req_rec,
	input  wire logic       i_send_tmpl,
	input  wire logic [3:0] i_delay,
	output logic            o_rec_done
);
	logic [3:0] wait_ff;

	// Gap after each pulse so a stale request is never answered twice
	always @(posedge i_clock) begin
		if (!i_rst_n || o_rec_done || !(i_req_rec || i_send_tmpl)) begin
			wait_ff    <= 4'h0;
			o_rec_done <= 1'b0;
		end else if (wait_ff >= i_delay) begin
			o_rec_done <= 1'b1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule : vcfc_host_model

/* logic/vcfc_core.sv */
// Behaviour
// RULE_01: End on pause: 7.5 s speech or 240 ms
// RULE_02: Low flag bits: pause, 6k, voice, rewind, reserved
// RULE_03: High flag bits: resident, state change, DTMF
// RULE_04: Host writes reserved bit 4 as zero
// RULE_05: Rate bit ignored for compression, error on telephone
// RULE_06: Voice detect interrupts decode during played silence
// RULE_07: Rewind restarts recognition at word end index
// RULE_08: Resident templates skip template requests
// RULE_09: State change aborts with matching status
// RULE_10: State abort only for audio ops and answer
// RULE_11: DTMF status with tone code word appended
// RULE_12: Features gated by control firmware revision
// RULE_13: Continuous recognition returns many event records
// RULE_14: Processed audio held until next command
// RULE_15: Extraction only after recognition or extraction
// RULE_16: Extraction takes event, returns template, status four
// RULE_17: Continuous training returns six byte status
// RULE_18: Continuous load like isolated, no voice processing
// RULE_19: Host sends fresh control record every start
// RULE_20: Status high byte always zero
// RULE_21: Busy error on command during running command
`timescale 1ns/1ns
`include "vcfc_consts.svh"

module vcfc_core #(
	parameter int unsigned SPEECH_MAX_CYC = `VCFC_SPEECH_MAX_CYC,
	parameter int unsigned PAUSE_CYC      = `VCFC_PAUSE_CYC
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_cmd_valid,
	input  wire logic        i_tel_cmd,
	input  wire logic [7:0]  i_func,
	input  wire logic [7:0]  i_flags,
	input  wire logic [7:0]  i_word_end,
	input  wire logic        i_rec_done,
	input  wire logic        i_op_done,
	input  wire logic        i_op_error,
	input  wire logic [7:0]  i_op_code,
	input  wire logic [7:0]  i_peak,
	input  wire logic [7:0]  i_noise,
	input  wire logic        i_speech,
	input  wire logic        i_play_silence,
	input  wire logic        i_word_event,
	input  wire logic [7:0]  i_word_event_idx,
	input  wire logic        i_dtmf_valid,
	input  wire logic [7:0]  i_dtmf_code,
	input  wire logic        i_ring,
	input  wire logic        i_hook_off,
	output logic             o_req_rec,
	output logic [1:0]       o_req_kind,
	output logic             o_send_tmpl,
	output logic             o_audio_run,
	output logic             o_rate_6k,
	output logic             o_rewind,
	output logic [7:0]       o_rewind_idx,
	output logic             o_event_valid,
	output logic [7:0]       o_event_idx,
	output logic             o_stat_valid,
	output logic [7:0]       o_stat_len,
	output logic [15:0]      o_stat_word,
	output logic [15:0]      o_stat_extra,
	output logic             o_busy_err,
	output logic             o_buf_hold
);
	import vcfc_pkg::*;

	// Firmware identity; values are arbitrary defaults
	localparam logic [7:0] CP_VER = `VCFC_FW_VER_DEF;
	localparam logic [7:0] CP_REV = `VCFC_FW_REV_DEF;

	vcfc_core_t q_ff;
	vcfc_core_t nxt_q;
	logic       pause_stop;

	function automatic logic fw_at_least(input int unsigned need);
		return (int'(CP_VER) * 100 + int'(CP_REV)) >= need;
	endfunction : fw_at_least

	// Commands that move audio in or out, plus telephone answer
	function automatic logic is_audio_op(input logic [7:0] fn, input logic tel);
		return tel || fn == `VCFC_FN_TRAIN_ISO || fn == `VCFC_FN_TRAIN_CX // RULE_10
			|| fn == `VCFC_FN_ENCODE || fn == `VCFC_FN_DECODE
			|| fn == `VCFC_FN_RECOG_ISO || fn == `VCFC_FN_RECOG_CX;
	endfunction : is_audio_op

	vcfc_pause_timer #(
		.SPEECH_MAX_CYC (SPEECH_MAX_CYC),
		.PAUSE_CYC      (PAUSE_CYC)
	) u_pause (
		.i_clock  (i_clock),
		.i_rst_n  (i_rst_n),
		.i_run    (q_ff.st == VCFC_RUN && q_ff.func == `VCFC_FN_RECOG_CX && !q_ff.tel
			&& q_ff.flags[`VCFC_FLAG_END_PAUSE]), // RULE_01
		.i_speech (i_speech),
		.o_stop   (pause_stop)
	);

	logic hook_chg;
	logic state_abort_on;
	logic dtmf_on;
	logic voice_on;
	assign hook_chg  = q_ff.hook_q ^ q_ff.hook_s[1];
	assign state_abort_on = q_ff.flags[`VCFC_FLAG_STATE_INT] // RULE_03
		&& is_audio_op(q_ff.func, q_ff.tel) && fw_at_least(`VCFC_FW_STATE_INT); // RULE_12
	assign dtmf_on = q_ff.flags[`VCFC_FLAG_DTMF_INT] // RULE_03
		&& is_audio_op(q_ff.func, q_ff.tel) && fw_at_least(`VCFC_FW_DTMF_INT); // RULE_12
	assign voice_on = q_ff.flags[`VCFC_FLAG_VOICE_DET] && !q_ff.tel // RULE_02
		&& q_ff.func == `VCFC_FN_DECODE && fw_at_least(`VCFC_FW_VOICE_DET); // RULE_06

	always_comb begin
		nxt_q             = q_ff;
		nxt_q.rewind      = 1'b0;
		nxt_q.event_valid = 1'b0;
		nxt_q.stat_valid  = 1'b0;
		nxt_q.busy_err    = 1'b0;
		// Line and deskset pins are asynchronous to this clock
		nxt_q.ring_s = {q_ff.ring_s[0], i_ring};
		nxt_q.hook_s = {q_ff.hook_s[0], i_hook_off};
		nxt_q.ring_q = q_ff.ring_s[1];
		nxt_q.hook_q = q_ff.hook_s[1];
		if (i_cmd_valid && q_ff.st != VCFC_IDLE) begin
			nxt_q.busy_err = 1'b1; // RULE_21
		end
		case (q_ff.st)
			VCFC_IDLE: begin
				if (i_cmd_valid) begin
					// Every start latches a fresh control record
					nxt_q.func      = i_func; // RULE_19
					nxt_q.flags     = i_flags;
					nxt_q.tel       = i_tel_cmd;
					nxt_q.wend      = i_word_end;
					nxt_q.code      = `VCFC_ST_OK;
					nxt_q.len       = `VCFC_LEN_PLAIN;
					nxt_q.extra     = 16'h0000;
					nxt_q.continuous_recognition_prev = 1'b0;
					// Buffered audio survives only into an extraction
					nxt_q.buf_hold  = q_ff.buf_hold && !i_tel_cmd
						&& i_func == `VCFC_FN_EXTRACT_CX; // RULE_14
					nxt_q.st        = VCFC_RUN;
					if (i_tel_cmd) begin
						if (i_flags[`VCFC_FLAG_RATE_6K]) begin
							nxt_q.code = `VCFC_ST_PARAM; // RULE_05
							nxt_q.st   = VCFC_STATUS;
						end
					end else begin
						case (i_func)
							`VCFC_FN_NOP: begin
								nxt_q.len   = `VCFC_LEN_NOP;
								nxt_q.extra = {CP_VER, CP_REV}; // RULE_12
								nxt_q.st    = VCFC_STATUS;
							end
							`VCFC_FN_LOAD_ISO, `VCFC_FN_LOAD_CX: begin
								nxt_q.st = VCFC_TLEN; // RULE_18
							end
							`VCFC_FN_RECOG_ISO, `VCFC_FN_RECOG_CX: begin
								if (!i_flags[`VCFC_FLAG_RESIDENT]) begin
									nxt_q.st = VCFC_TLEN; // RULE_08
								end
							end
							`VCFC_FN_EXTRACT_CX: begin
								// Wrong predecessor is flagged, not run
								nxt_q.st = q_ff.continuous_recognition_prev ? VCFC_EVENT : VCFC_STATUS; // RULE_15
								if (!q_ff.continuous_recognition_prev) begin
									nxt_q.code = `VCFC_ST_INVALID;
								end
							end
							`VCFC_FN_TRAIN_ISO, `VCFC_FN_TRAIN_CX, `VCFC_FN_ENCODE,
							`VCFC_FN_DECODE, `VCFC_FN_TONE: begin
								nxt_q.st = VCFC_RUN;
							end
							default: begin
								nxt_q.code = `VCFC_ST_PARAM;
								nxt_q.st   = VCFC_STATUS;
							end
						endcase
					end
					if (!i_tel_cmd && i_func == `VCFC_FN_RECOG_CX && nxt_q.st == VCFC_RUN
						&& i_flags[`VCFC_FLAG_REWIND]) begin
						nxt_q.rewind     = 1'b1; // RULE_07
						nxt_q.rewind_idx = i_word_end;
					end
				end
			end
			VCFC_TLEN: begin
				if (i_rec_done) begin
					nxt_q.st = VCFC_TMPL; // RULE_08
				end
			end
			VCFC_TMPL: begin
				if (i_rec_done) begin
					if (q_ff.func == `VCFC_FN_LOAD_ISO || q_ff.func == `VCFC_FN_LOAD_CX) begin
						nxt_q.st = VCFC_STATUS; // RULE_18
					end else begin
						nxt_q.st = VCFC_RUN;
						if (q_ff.func == `VCFC_FN_RECOG_CX && q_ff.flags[`VCFC_FLAG_REWIND]) begin
							nxt_q.rewind     = 1'b1; // RULE_07
							nxt_q.rewind_idx = q_ff.wend;
						end
					end
				end
			end
			VCFC_RUN: begin
				if (i_word_event && q_ff.func == `VCFC_FN_RECOG_CX && !q_ff.tel) begin
					nxt_q.event_valid = 1'b1; // RULE_13
					nxt_q.event_idx   = i_word_event_idx;
				end
				// Abort causes outrank normal completion
				if (state_abort_on && (q_ff.ring_q || hook_chg)) begin
					nxt_q.st   = VCFC_STATUS; // RULE_09
					nxt_q.code = hook_chg ? (q_ff.hook_s[1] ? `VCFC_ST_OFF_HOOK : `VCFC_ST_ON_HOOK)
						: `VCFC_ST_RING;
				end else if (dtmf_on && i_dtmf_valid) begin
					nxt_q.st    = VCFC_STATUS;
					nxt_q.code  = `VCFC_ST_DTMF; // RULE_11
					nxt_q.len   = `VCFC_LEN_DTMF;
					nxt_q.extra = {8'h00, i_dtmf_code};
				end else if (voice_on && i_speech && i_play_silence) begin
					nxt_q.st   = VCFC_STATUS; // RULE_06
					nxt_q.code = `VCFC_ST_VOICE;
				end else if (pause_stop) begin
					nxt_q.st = VCFC_STATUS; // RULE_01
				end else if (i_op_error) begin
					nxt_q.st   = VCFC_STATUS;
					nxt_q.code = i_op_code;
				end else if (i_op_done) begin
					nxt_q.st = VCFC_STATUS;
					if (!q_ff.tel && (q_ff.func == `VCFC_FN_TRAIN_CX
						|| q_ff.func == `VCFC_FN_TRAIN_ISO)) begin
						nxt_q.st    = VCFC_SEND; // RULE_17
						nxt_q.len   = `VCFC_LEN_TRAIN;
						nxt_q.extra = {i_noise, i_peak};
					end
				end
			end
			VCFC_EVENT: begin
				if (i_rec_done) begin
					nxt_q.st = VCFC_SEND; // RULE_16
				end
			end
			VCFC_SEND: begin
				if (i_rec_done) begin
					nxt_q.st = VCFC_STATUS;
				end
			end
			VCFC_STATUS: begin
				nxt_q.stat_valid = 1'b1;
				nxt_q.stat_len   = q_ff.len;
				nxt_q.stat_word  = {8'h00, q_ff.code}; // RULE_20
				nxt_q.stat_extra = q_ff.extra;
				nxt_q.st         = VCFC_IDLE;
				if (!q_ff.tel && q_ff.code == `VCFC_ST_OK && (q_ff.func == `VCFC_FN_RECOG_CX
					|| q_ff.func == `VCFC_FN_EXTRACT_CX)) begin
					nxt_q.continuous_recognition_prev = 1'b1;
					nxt_q.buf_hold  = 1'b1; // RULE_14
				end
			end
			default: begin
				nxt_q.st = VCFC_IDLE;
			end
		endcase
		nxt_q.req_rec   = nxt_q.st == VCFC_TLEN || nxt_q.st == VCFC_TMPL || nxt_q.st == VCFC_EVENT;
		nxt_q.req_kind  = nxt_q.st == VCFC_TMPL ? `VCFC_KIND_TMPL
			: nxt_q.st == VCFC_EVENT ? `VCFC_KIND_EVENT : `VCFC_KIND_TLEN;
		nxt_q.send_tmpl = nxt_q.st == VCFC_SEND;
		nxt_q.audio_run = nxt_q.st == VCFC_RUN;
		// Compression always runs at the default rate
		nxt_q.rate_6k   = nxt_q.st == VCFC_RUN && nxt_q.flags[`VCFC_FLAG_RATE_6K] && !nxt_q.tel
			&& nxt_q.func != `VCFC_FN_ENCODE && nxt_q.func != `VCFC_FN_DECODE; // RULE_05
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			q_ff    <= '0;
			q_ff.st <= VCFC_IDLE;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign o_req_rec     = q_ff.req_rec;
	assign o_req_kind    = q_ff.req_kind;
	assign o_send_tmpl   = q_ff.send_tmpl;
	assign o_audio_run   = q_ff.audio_run;
	assign o_rate_6k     = q_ff.rate_6k;
	assign o_rewind      = q_ff.rewind;
	assign o_rewind_idx  = q_ff.rewind_idx;
	assign o_event_valid = q_ff.event_valid;
	assign o_event_idx   = q_ff.event_idx;
	assign o_stat_valid  = q_ff.stat_valid;
	assign o_stat_len    = q_ff.stat_len;
	assign o_stat_word   = q_ff.stat_word;
	assign o_stat_extra  = q_ff.stat_extra;
	assign o_busy_err    = q_ff.busy_err;
	assign o_buf_hold    = q_ff.buf_hold;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_busy_report: assert property (i_cmd_valid && q_ff.st != VCFC_IDLE |=> o_busy_err) // RULE_21
		else $error("busy error not reported");
	a_stat_high: assert property (o_stat_valid |-> o_stat_word[15:8] == 8'h00) // RULE_20
		else $error("status high byte not zero");
	a_dtmf_word: assert property (o_stat_valid && o_stat_word[7:0] == `VCFC_ST_DTMF // RULE_11
		|-> o_stat_len == `VCFC_LEN_DTMF && o_stat_extra[15:8] == 8'h00)
		else $error("dtmf status record malformed");
	a_train_len: assert property (o_stat_valid && q_ff.func == `VCFC_FN_TRAIN_CX // RULE_17
		&& o_stat_word == 16'h0000 |-> o_stat_len == `VCFC_LEN_TRAIN)
		else $error("train status length wrong");
	a_no_request: assert property (o_req_rec && q_ff.func == `VCFC_FN_RECOG_CX // RULE_08
		|-> !q_ff.flags[`VCFC_FLAG_RESIDENT])
		else $error("templates requested while resident");
	a_load_quiet: assert property (q_ff.func == `VCFC_FN_LOAD_CX && !q_ff.tel // RULE_18
		|-> !o_audio_run)
		else $error("template load ran audio");
	a_rewind_idx: assert property (o_rewind |-> o_rewind_idx == q_ff.wend // RULE_07
		&& q_ff.flags[`VCFC_FLAG_REWIND])
		else $error("rewind index mismatch");
	a_ring_abort: assert property (q_ff.st == VCFC_RUN && state_abort_on && q_ff.ring_q // RULE_09
		&& !hook_chg |=> ##1 o_stat_valid && o_stat_word[7:0] == `VCFC_ST_RING)
		else $error("ring did not abort");
	a_rate_comp: assert property (o_rate_6k |-> q_ff.func != `VCFC_FN_ENCODE // RULE_05
		&& q_ff.func != `VCFC_FN_DECODE)
		else $error("rate bit applied to compression");
	a_pause_end: assert property (q_ff.st == VCFC_RUN && pause_stop |=> ##1 o_stat_valid) // RULE_01
		else $error("end on pause did not finish");
	a_event_out: assert property (q_ff.st == VCFC_RUN && i_word_event && !q_ff.tel // RULE_13
		&& q_ff.func == `VCFC_FN_RECOG_CX |=> o_event_valid && o_event_idx == $past(i_word_event_idx))
		else $error("event record lost");
	a_hold_buf: assert property (o_buf_hold |-> q_ff.st == VCFC_IDLE // RULE_14
		|| q_ff.func == `VCFC_FN_EXTRACT_CX)
		else $error("audio held into other command");

	c_event: cover property (o_event_valid ##[1:50] o_stat_valid);
	c_extract: cover property (o_stat_valid && q_ff.func == `VCFC_FN_EXTRACT_CX
		&& o_stat_word == 16'h0000);
	c_dtmf: cover property (o_stat_valid && o_stat_word[7:0] == `VCFC_ST_DTMF);
	c_busy: cover property (o_busy_err);

endmodule : vcfc_core

/* logic/vcfc_pause_timer.sv */
`timescale 1ns/1ns
`include "vcfc_consts.svh"

module vcfc_pause_timer #(
	parameter int unsigned SPEECH_MAX_CYC = `VCFC_SPEECH_MAX_CYC,
	parameter int unsigned PAUSE_CYC      = `VCFC_PAUSE_CYC
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	input  wire logic i_speech,
	output logic      o_stop
);
	import vcfc_pkg::*;

	vcfc_timer_t q_ff;
	vcfc_timer_t nxt_q;

	always_comb begin
		nxt_q      = q_ff;
		nxt_q.stop = 1'b0;
		if (!i_run) begin
			nxt_q = '0;
		end else if (i_speech) begin
			// A pause restarts the unbroken-speech count
			nxt_q.heard       = 1'b1;
			nxt_q.silence_cnt = '0;
			nxt_q.speech_cnt  = q_ff.speech_cnt + 30'h0000_0001;
			nxt_q.stop        = (nxt_q.speech_cnt >= `VCFC_CNT_W'(SPEECH_MAX_CYC)); // RULE_01
		end else begin
			nxt_q.speech_cnt = '0;
			if (q_ff.heard) begin
				nxt_q.silence_cnt = q_ff.silence_cnt + 30'h0000_0001;
				nxt_q.stop        = (nxt_q.silence_cnt >= `VCFC_CNT_W'(PAUSE_CYC)); // RULE_01
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign o_stop = q_ff.stop;

endmodule : vcfc_pause_timer
